// *** shared/fecap_pkg.sv ***
// shared constants for the far-end capability register slice
package fecap_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CAP_LOW = 8'h20;
	localparam logic [7:0] IDX_CAP_HIGH = 8'h21;
	localparam logic [7:0] IDX_LD_CTRL = 8'h26;
	localparam logic [7:0] IDX_PORT_CTRL = 8'h28;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h29;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h2A;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h2B;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;

	// field positions in the low capability register, then load, high-field and timer-select widths
	localparam int FREEZE_BIT = 7;
	localparam int MODE0_BIT = 6;
	localparam int TWO_LANE_BIT = 3;
	localparam int CHAN_ROLE_BIT = 2;
	localparam int DEEP_COLOR_BIT = 1;
	localparam int FWD_PIN_BIT = 0;
	localparam int LOAD_W = 7;
	localparam int MODE_HI_W = 2;
	localparam int LDT_SEL_W = 3;

	// interrupt status bits
	localparam int IRQ_LINK_LOST = 0;
	localparam int IRQ_CAP_LOADED = 1;
	localparam int IRQ_W = 2;

	// values after reset
	localparam logic [7:0] CAP_LOW_RESET = 8'h00;
	localparam logic [1:0] CAP_HIGH_RESET = 2'h0;
	localparam logic [2:0] LDT_SEL_RESET = 3'h0;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// control channel modes
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_GPIO1 = 3'h1,
		MODE_GPIO2 = 3'h2,
		MODE_GPIO4 = 3'h3,
		MODE_RSVD4 = 3'h4,
		MODE_RSVD5 = 3'h5,
		MODE_SPI_FWD = 3'h6,
		MODE_SPI_REV = 3'h7
	} fecap_mode_t;

	// link-detect timeouts in nanoseconds, indexed by the timer select
	localparam int CLK_PERIOD_NS = 25;
	localparam int LDT_0_NS = 162000;
	localparam int LDT_1_NS = 325000;
	localparam int LDT_2_NS = 650000;
	localparam int LDT_3_NS = 1300000;
	localparam int LDT_4_NS = 10250;
	localparam int LDT_5_NS = 20500;
	localparam int LDT_6_NS = 41000;
	localparam int LDT_7_NS = 82000;
	// least times, rounded up to whole cycles
	localparam int LDT_0_CYC = (LDT_0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_1_CYC = (LDT_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_2_CYC = (LDT_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_3_CYC = (LDT_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_4_CYC = (LDT_4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_5_CYC = (LDT_5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_6_CYC = (LDT_6_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_7_CYC = (LDT_7_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LDT_CNT_W = 16;

	// number of high-speed gpios a mode carries; reserved modes carry none
	function automatic logic [2:0] gpio_count(input logic [2:0] mode);
		case (fecap_mode_t'(mode))
			MODE_GPIO1: gpio_count = 3'h1;
			MODE_GPIO2: gpio_count = 3'h2;
			MODE_GPIO4: gpio_count = 3'h4;
			default: gpio_count = 3'h0;
		endcase
	endfunction
endpackage

// *** design/fecap_link_timer.sv ***
// link-detect watchdog for one port
`timescale 1ns/1ps
module fecap_link_timer #(
	parameter int CNT_W = 16,
	parameter logic [8*16-1:0] LIMITS = '1
)(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic i_enable,
	input wire logic i_valid_comm,
	input wire logic [2:0] i_sel,
	// status
	output logic o_link_detect,
	output logic o_lost
);
	if (CNT_W != 16) begin : g_bad_width
		$error("fecap_link_timer: limits are packed 16 bits wide");
	end

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] limit;
	logic next_link_detect;
	logic next_lost;

	assign limit = LIMITS[i_sel*CNT_W +: CNT_W];

	always_comb
	begin
		next_cnt = cnt;
		next_link_detect = o_link_detect;
		next_lost = 1'b0;
		if (!i_enable)
		begin
			next_cnt = '0;
			next_link_detect = 1'b0;
		end
		else if (i_valid_comm)
		begin
			next_cnt = '0;
			next_link_detect = 1'b1;
		end
		else if (o_link_detect)
		begin
			if (cnt >= limit - 1'b1)
			begin
				next_cnt = '0;
				next_link_detect = 1'b0;
				next_lost = 1'b1;
			end
			else
			begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cnt <= '0;
			o_link_detect <= 1'b0;
			o_lost <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			o_link_detect <= next_link_detect;
			o_lost <= next_lost;
		end
	end

	chk_silence_drop: assert property (@(posedge clk) disable iff (reset)
		o_link_detect && i_enable && !i_valid_comm && cnt == limit - 1'b1 |=> !o_link_detect && o_lost)
		else $error("link detect held past its timeout");
	chk_detect_cause: assert property (@(posedge clk) disable iff (reset)
		$rose(o_link_detect) |-> $past(i_valid_comm) && $past(i_enable))
		else $error("link detect rose without valid communication");
endmodule

// *** design/fecap_regs.sv ***
// far-end capability registers, link-detect timing and apb slave
// Summary of operation
// - channel-role bit reads 0 for primary channel, 1 for secondary channel
// - capability fields auto-load from the far end after receive lock
// - freeze (low bit 7) stops auto-loading and keeps both registers
// - second-port select steers capability reads and writes to port one, except in single-link builds
// - low bit 1 flags deep colour together with high-quality sound
// - low bit 0 flags gpio carried in the forward frame
// - mode is high bits 1:0 above one bit of the low register
// - lowest mode bit lives in low register bit 6
// - mode decodes normal, 1/2/4 fast gpios, reserved, forward or reverse spi
// - single-link builds use only the normal back-channel mode
// - link detect drops when the timer expires without valid traffic
// - timeout select picks 162u,325u,650u,1.3m,10.25u,20.5u,41u,82u
`timescale 1ns/1ps
module fecap_regs #(
	parameter int ADDR_W = 12,
	parameter bit SINGLE_LINK = 1'b0,
	parameter int LDT_0_CYC = fecap_pkg::LDT_0_CYC,
	parameter int LDT_1_CYC = fecap_pkg::LDT_1_CYC,
	parameter int LDT_2_CYC = fecap_pkg::LDT_2_CYC,
	parameter int LDT_3_CYC = fecap_pkg::LDT_3_CYC
)(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RESET,
	// apb slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic O_PSLVERR,
	// auto-load from the control channel
	input wire logic I_CAP_LOAD,
	input wire logic I_CAP_LOAD_PORT,
	input wire logic [6:0] I_CAP_LOAD_LOW,
	input wire logic [1:0] I_CAP_LOAD_HIGH,
	input wire logic [1:0] I_RX_LOCK,
	input wire logic [1:0] I_VALID_COMM,
	// per-port status, port p at bit p, or at bits 3p+2:3p for the three-bit fields
	output logic [1:0] O_LINK_DETECT,
	output logic [5:0] O_CONTROL_CHANNEL_MODE,
	output logic [5:0] O_HS_GPIO_COUNT,
	output logic [1:0] O_HS_SPI_FWD,
	output logic [1:0] O_HS_SPI_REV,
	// interrupt
	output logic O_IRQ
);
	if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr
		$error("fecap_regs: address width must be 11 to 32");
	end
	if (LDT_3_CYC > 65535 || LDT_0_CYC < 1 || LDT_1_CYC < 1 || LDT_2_CYC < 1) begin : g_bad_ldt
		$error("fecap_regs: timeout counts must fit 16 bits");
	end

	localparam logic [8*16-1:0] LDT_LIMITS = {
		16'(fecap_pkg::LDT_7_CYC), 16'(fecap_pkg::LDT_6_CYC),
		16'(fecap_pkg::LDT_5_CYC), 16'(fecap_pkg::LDT_4_CYC),
		16'(LDT_3_CYC), 16'(LDT_2_CYC), 16'(LDT_1_CYC), 16'(LDT_0_CYC)};

	logic [7:0] cap_low [2];
	logic [1:0] cap_high [2];
	logic [7:0] next_cap_low [2];
	logic [1:0] next_cap_high [2];
	logic [1:0] load_ok;
	logic [1:0] lost;
	logic port_sel;
	logic next_port_sel;
	logic active_port;
	logic [2:0] ldt_sel;
	logic [2:0] next_ldt_sel;
	logic [1:0] irq_status;
	logic [1:0] next_irq_status;
	logic [1:0] irq_enable;
	logic [1:0] next_irq_enable;
	logic [1:0] irq_event;
	logic [1:0] irq_clear;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [7:0] idx;
	logic hit;
	logic mapped;
	logic [31:0] rd_value;
	logic wr;

	assign idx = I_PADDR[fecap_pkg::IDX_LSB +: fecap_pkg::IDX_W];
	assign mapped = hit && I_PADDR[1:0] == 2'h0 && (I_PADDR >> (fecap_pkg::IDX_LSB + fecap_pkg::IDX_W)) == '0;
	// zero-wait slave: access phase always completes
	assign O_PREADY = I_PSEL && I_PENABLE;
	// data lives in lane 0, so a write without that strobe changes nothing
	assign wr = I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0] && mapped;
	// port select; single-link parts only have port zero
	assign active_port = port_sel && !SINGLE_LINK;

	always_comb
	begin
		hit = 1'b1;
		rd_value = 32'h0000_0000;
		case (idx)
			fecap_pkg::IDX_CAP_LOW: rd_value[7:0] = cap_low[active_port];
			fecap_pkg::IDX_CAP_HIGH: rd_value[1:0] = cap_high[active_port];
			fecap_pkg::IDX_LD_CTRL: rd_value[2:0] = ldt_sel;
			fecap_pkg::IDX_PORT_CTRL: rd_value[0] = port_sel;
			fecap_pkg::IDX_IRQ_STATUS: rd_value[1:0] = irq_status;
			fecap_pkg::IDX_IRQ_CLEAR: rd_value = 32'h0000_0000;
			fecap_pkg::IDX_IRQ_ENABLE: rd_value[1:0] = irq_enable;
			default: hit = 1'b0;
		endcase
	end

	// read data is captured in the setup phase and held through access
	always_comb
	begin
		next_prdata = O_PRDATA;
		next_pslverr = O_PSLVERR;
		if (I_PSEL && !I_PENABLE)
		begin
			next_prdata = (mapped && !I_PWRITE) ? rd_value : 32'h0000_0000;
			next_pslverr = !mapped;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			O_PRDATA <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end
		else
		begin
			O_PRDATA <= next_prdata;
			O_PSLVERR <= next_pslverr;
		end
	end

	for (genvar p = 0; p < 2; p++)
	begin : g_port
		logic [2:0] mode;
		logic [2:0] eff_mode;
		logic sw_low;
		logic sw_high;

		assign sw_low = wr && idx == fecap_pkg::IDX_CAP_LOW && active_port == p;
		assign sw_high = wr && idx == fecap_pkg::IDX_CAP_HIGH && active_port == p;
		// load only after lock and only while not frozen
		assign load_ok[p] = I_CAP_LOAD && I_CAP_LOAD_PORT == p && I_RX_LOCK[p]
			&& !cap_low[p][fecap_pkg::FREEZE_BIT];
		assign mode = {cap_high[p], cap_low[p][fecap_pkg::MODE0_BIT]};
		// single link falls back to the normal back-channel frame
		assign eff_mode = SINGLE_LINK ? fecap_pkg::MODE_NORMAL : mode;

		always_comb
		begin
			next_cap_low[p] = cap_low[p];
			next_cap_high[p] = cap_high[p];
			if (load_ok[p])
			begin
				next_cap_low[p][fecap_pkg::LOAD_W-1:0] = I_CAP_LOAD_LOW;
				next_cap_high[p] = I_CAP_LOAD_HIGH;
			end
			// software wins a same-cycle collision; freeze only comes from here
			if (sw_low)
			begin
				next_cap_low[p] = I_PWDATA[7:0];
			end
			if (sw_high)
			begin
				next_cap_high[p] = I_PWDATA[fecap_pkg::MODE_HI_W-1:0];
			end
		end

		always_ff @(posedge I_CLK or posedge I_RESET)
		begin
			if (I_RESET)
			begin
				cap_low[p] <= fecap_pkg::CAP_LOW_RESET;
				cap_high[p] <= fecap_pkg::CAP_HIGH_RESET;
				O_CONTROL_CHANNEL_MODE[3*p +: 3] <= 3'h0;
				O_HS_GPIO_COUNT[3*p +: 3] <= 3'h0;
				O_HS_SPI_FWD[p] <= 1'b0;
				O_HS_SPI_REV[p] <= 1'b0;
			end
			else
			begin
				cap_low[p] <= next_cap_low[p];
				cap_high[p] <= next_cap_high[p];
				O_CONTROL_CHANNEL_MODE[3*p +: 3] <= eff_mode;
				O_HS_GPIO_COUNT[3*p +: 3] <= fecap_pkg::gpio_count(eff_mode);
				O_HS_SPI_FWD[p] <= eff_mode == fecap_pkg::MODE_SPI_FWD;
				O_HS_SPI_REV[p] <= eff_mode == fecap_pkg::MODE_SPI_REV;
			end
		end

		fecap_link_timer #(
			.CNT_W(fecap_pkg::LDT_CNT_W),
			.LIMITS(LDT_LIMITS)
		) u_timer (
			.clk(I_CLK),
			.reset(I_RESET),
			.i_enable(I_RX_LOCK[p]),
			.i_valid_comm(I_VALID_COMM[p]),
			.i_sel(ldt_sel),
			.o_link_detect(O_LINK_DETECT[p]),
			.o_lost(lost[p])
		);
	end

	assign irq_event[fecap_pkg::IRQ_LINK_LOST] = |lost;
	assign irq_event[fecap_pkg::IRQ_CAP_LOADED] = |load_ok;
	assign irq_clear = (wr && idx == fecap_pkg::IDX_IRQ_CLEAR) ? I_PWDATA[1:0] : 2'h0;
	assign O_IRQ = |(irq_status & irq_enable);

	always_comb
	begin
		next_port_sel = port_sel;
		next_ldt_sel = ldt_sel;
		next_irq_enable = irq_enable;
		// a new event beats a clear in the same cycle
		next_irq_status = (irq_status & ~irq_clear) | irq_event;
		if (wr && idx == fecap_pkg::IDX_PORT_CTRL)
		begin
			next_port_sel = I_PWDATA[0];
		end
		if (wr && idx == fecap_pkg::IDX_LD_CTRL)
		begin
			next_ldt_sel = I_PWDATA[fecap_pkg::LDT_SEL_W-1:0];
		end
		if (wr && idx == fecap_pkg::IDX_IRQ_ENABLE)
		begin
			next_irq_enable = I_PWDATA[fecap_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge I_CLK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			port_sel <= 1'b0;
			ldt_sel <= fecap_pkg::LDT_SEL_RESET;
			irq_status <= fecap_pkg::IRQ_RESET;
			irq_enable <= fecap_pkg::IRQ_RESET;
		end
		else
		begin
			port_sel <= next_port_sel;
			ldt_sel <= next_ldt_sel;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
		end
	end

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RESET);

	sequence load_p0;
		I_CAP_LOAD && !I_CAP_LOAD_PORT && I_RX_LOCK[0] && !cap_low[0][7] && !g_port[0].sw_low && !g_port[0].sw_high;
	endsequence

	chk_role_load: assert property (load_p0 |=> cap_low[0][2] == $past(I_CAP_LOAD_LOW[2]))
		else $error("channel role bit not loaded");
	chk_autoload_lock: assert property (
		I_CAP_LOAD && !I_CAP_LOAD_PORT && !I_RX_LOCK[0] && !g_port[0].sw_low |=> $stable(cap_low[0]))
		else $error("capabilities loaded without lock");
	chk_freeze_hold: assert property (
		cap_low[0][7] && !g_port[0].sw_low && !g_port[0].sw_high |=> $stable(cap_low[0]) && $stable(cap_high[0]))
		else $error("frozen capabilities changed");
	chk_port_select: assert property (
		I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == 12'h080 && port_sel && !SINGLE_LINK
		|=> O_PRDATA[7:0] == $past(cap_low[1]))
		else $error("port select did not steer the read");
	chk_deep_color: assert property (load_p0 |=> cap_low[0][1] == $past(I_CAP_LOAD_LOW[1]))
		else $error("deep colour bit not loaded");
	chk_fwd_pin: assert property (load_p0 |=> cap_low[0][0] == $past(I_CAP_LOAD_LOW[0]))
		else $error("forward gpio bit not loaded");
	chk_mode_join: assert property (!SINGLE_LINK |=>
		O_CONTROL_CHANNEL_MODE[2:0] == $past({cap_high[0], cap_low[0][6]}))
		else $error("mode not formed from both registers");
	chk_mode_low_bit: assert property ((load_p0 and !SINGLE_LINK) |=> ##1
		O_CONTROL_CHANNEL_MODE[0] == $past(I_CAP_LOAD_LOW[6], 2))
		else $error("lowest mode bit not from bit 6");
	chk_mode_decode: assert property (
		O_CONTROL_CHANNEL_MODE[2:0] == 3'h3 |-> O_HS_GPIO_COUNT[2:0] == 3'h4 && !O_HS_SPI_FWD[0] && !O_HS_SPI_REV[0])
		else $error("four-gpio mode decoded wrong");
	chk_single_link: assert property (SINGLE_LINK |-> O_CONTROL_CHANNEL_MODE == 6'h00
		&& O_HS_GPIO_COUNT == 6'h00 && O_HS_SPI_FWD == 2'h0 && O_HS_SPI_REV == 2'h0)
		else $error("high-speed mode on a single link");
	chk_timeout_short: assert property (
		ldt_sel == 3'h4 |-> g_port[0].u_timer.limit == 16'(fecap_pkg::LDT_4_CYC))
		else $error("timeout select picked wrong limit");
	chk_two_lane: assert property (load_p0 |=> cap_low[0][3] == $past(I_CAP_LOAD_LOW[3]))
		else $error("two-lane bit not loaded");
	chk_irq_sticky: assert property ($rose(lost[0]) |=> irq_status[fecap_pkg::IRQ_LINK_LOST])
		else $error("link loss not recorded");

	cov_autoload: cover property (load_p0 ##1 cap_low[0][6]);
	cov_freeze_blocks: cover property (I_CAP_LOAD && I_RX_LOCK[0] && cap_low[0][7]);
	cov_link_lost: cover property (O_LINK_DETECT[0] ##1 !O_LINK_DETECT[0] && I_RX_LOCK[0]);
	cov_irq: cover property ($rose(O_IRQ));
endmodule

// *** tb/fecap_far_end.sv ***
// far-end model: receive lock, capability loads and reverse-channel traffic
`timescale 1ns/1ps
module fecap_far_end (
	// clock
	input wire logic clk,
	// towards the device
	output logic o_cap_load,
	output logic o_port,
	output logic [6:0] o_low,
	output logic [1:0] o_high,
	output logic [1:0] o_rx_lock,
	output logic [1:0] o_valid
);
	initial
	begin
		o_cap_load = 1'b0;
		o_port = 1'b0;
		o_low = 7'h00;
		o_high = 2'h0;
		o_rx_lock = 2'h0;
		o_valid = 2'h0;
	end
	task automatic lock(input logic [1:0] v);
		@(posedge clk);
		o_rx_lock <= v;
	endtask
	task automatic send(input logic p, input logic [6:0] lo, input logic [1:0] hi);
		@(posedge clk);
		o_cap_load <= 1'b1;
		o_port <= p;
		o_low <= lo;
		o_high <= hi;
		@(posedge clk);
		o_cap_load <= 1'b0;
		// idle lines show the inverse so stale data never looks like a load
		o_low <= ~lo;
		o_high <= ~hi;
	endtask
	task automatic talk(input int p);
		@(posedge clk);
		o_valid[p] <= 1'b1;
		@(posedge clk);
		o_valid[p] <= 1'b0;
	endtask
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the far-end capability registers
`timescale 1ns/1ps
module tb_top;
	localparam logic [11:0] A_LOW = {2'b00, fecap_pkg::IDX_CAP_LOW, 2'b00};
	localparam logic [11:0] A_HIGH = {2'b00, fecap_pkg::IDX_CAP_HIGH, 2'b00};
	localparam logic [11:0] A_LDT = {2'b00, fecap_pkg::IDX_LD_CTRL, 2'b00};
	localparam logic [11:0] A_PORT = {2'b00, fecap_pkg::IDX_PORT_CTRL, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, fecap_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [11:0] A_CLR = {2'b00, fecap_pkg::IDX_IRQ_CLEAR, 2'b00};
	localparam logic [11:0] A_EN = {2'b00, fecap_pkg::IDX_IRQ_ENABLE, 2'b00};
	logic clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] sl_rd;
	logic [5:0] sl_ccm;
	logic [5:0] sl_gpio;
	logic [1:0] sl_spif;
	logic [1:0] sl_spir;
	logic rdy;
	logic slverr;
	logic irq;
	logic [31:0] prdata;
	logic cl;
	logic cp;
	logic [6:0] clo;
	logic [1:0] chi;
	logic [1:0] lk;
	logic [1:0] vc;
	logic [1:0] det;
	logic [5:0] ccm;
	logic [5:0] gpio;
	logic [1:0] spif;
	logic [1:0] spir;
	int err_total = 0;
	int num_checks = 0;
	fecap_far_end far_u (.clk(clk), .o_cap_load(cl), .o_port(cp), .o_low(clo), .o_high(chi),
		.o_rx_lock(lk), .o_valid(vc));
	fecap_regs #(.LDT_0_CYC(20), .LDT_1_CYC(30), .LDT_2_CYC(40), .LDT_3_CYC(50)) dut_u (
		.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(rdy), .O_PRDATA(prdata),
		.O_PSLVERR(slverr), .I_CAP_LOAD(cl), .I_CAP_LOAD_PORT(cp), .I_CAP_LOAD_LOW(clo),
		.I_CAP_LOAD_HIGH(chi), .I_RX_LOCK(lk), .I_VALID_COMM(vc), .O_LINK_DETECT(det),
		.O_CONTROL_CHANNEL_MODE(ccm), .O_HS_GPIO_COUNT(gpio), .O_HS_SPI_FWD(spif),
		.O_HS_SPI_REV(spir), .O_IRQ(irq));
	// single-link build sharing the same stimulus
	fecap_regs #(.SINGLE_LINK(1'b1)) sl_u (
		.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PREADY(), .O_PRDATA(sl_rd),
		.O_PSLVERR(), .I_CAP_LOAD(cl), .I_CAP_LOAD_PORT(cp), .I_CAP_LOAD_LOW(clo),
		.I_CAP_LOAD_HIGH(chi), .I_RX_LOCK(lk), .I_VALID_COMM(vc), .O_LINK_DETECT(),
		.O_CONTROL_CHANNEL_MODE(sl_ccm), .O_HS_GPIO_COUNT(sl_gpio), .O_HS_SPI_FWD(sl_spif),
		.O_HS_SPI_REV(sl_spir), .O_IRQ());
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees ready
		do
		begin
			@(posedge clk);
		end
		while (rdy !== 1'b1);
		rd = prdata;
		er = slverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb(1'b1, a, wd, d, e);
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] d;
		logic e;
		apb(1'b0, a, 32'h0000_0000, d, e);
		chk(d, exp);
		chk(e, eexp);
	endtask
	task automatic t_reset();
		rchk(A_LOW, 32'h0000_0000, 1'b0);
		rchk(A_HIGH, 32'h0000_0000, 1'b0);
		rchk(A_LDT, 32'h0000_0000, 1'b0);
		rchk(12'h0B0, 32'h0000_0000, 1'b1);
		rchk(12'h081, 32'h0000_0000, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_autoload();
		far_u.lock(2'b01);
		far_u.send(1'b1, 7'h7F, 2'h3);
		far_u.send(1'b0, 7'h4D, 2'h3);
		rchk(A_LOW, 32'h0000_004D, 1'b0);
		rchk(A_HIGH, 32'h0000_0003, 1'b0);
		chk(ccm, 6'h07);
		chk(spir, 2'h1);
		far_u.send(1'b0, 7'h49, 2'h3);
		rchk(A_LOW, 32'h0000_0049, 1'b0);
		$display("test autoload done");
	endtask
	task automatic t_modes();
		logic [2:0] m;
		for (int i = 0; i < 8; i++)
		begin
			m = i[2:0];
			far_u.send(1'b0, {m[0], 6'h00}, m[2:1]);
			repeat (3) @(posedge clk);
			chk(ccm[2:0], m);
			chk(gpio[2:0], (m == 3'h1) ? 3'h1 : (m == 3'h2) ? 3'h2 : (m == 3'h3) ? 3'h4 : 3'h0);
			chk(spif[0], m == 3'h6);
			chk(spir[0], m == 3'h7);
			chk({sl_ccm, sl_gpio, sl_spif, sl_spir}, 16'h0000);
		end
		$display("test modes done");
	endtask
	task automatic t_freeze();
		// freeze set together with the written value
		wr(A_LOW, 32'h0000_0092);
		wr(A_HIGH, 32'h0000_0001);
		far_u.send(1'b0, 7'h7F, 2'h2);
		rchk(A_LOW, 32'h0000_0092, 1'b0);
		rchk(A_HIGH, 32'h0000_0001, 1'b0);
		chk(gpio[2:0], 3'h2);
		wr(A_LOW, 32'h0000_0000);
		far_u.send(1'b0, 7'h05, 2'h0);
		rchk(A_LOW, 32'h0000_0005, 1'b0);
		$display("test freeze done");
	endtask
	task automatic t_port();
		far_u.lock(2'b11);
		far_u.send(1'b1, 7'h46, 2'h2);
		wr(A_PORT, 32'h0000_0001);
		rchk(A_LOW, 32'h0000_0046, 1'b0);
		chk(sl_rd, 32'h0000_0005);
		rchk(A_HIGH, 32'h0000_0002, 1'b0);
		chk(ccm, 6'h28);
		chk(gpio, 6'h00);
		wr(A_LOW, 32'h0000_0001);
		rchk(A_LOW, 32'h0000_0001, 1'b0);
		wr(A_PORT, 32'h0000_0000);
		rchk(A_LOW, 32'h0000_0005, 1'b0);
		chk(ccm, 6'h20);
		$display("test port done");
	endtask
	task automatic t_irq();
		wr(A_EN, 32'h0000_0000);
		wr(A_CLR, 32'h0000_0003);
		far_u.send(1'b0, 7'h05, 2'h0);
		rchk(A_STAT, 32'h0000_0002, 1'b0);
		chk(irq, 1'b0);
		wr(A_EN, 32'h0000_0002);
		// the enable lands at the edge that ends the write
		@(posedge clk);
		chk(irq, 1'b1);
		wr(A_STAT, 32'h0000_0000);
		rchk(A_STAT, 32'h0000_0002, 1'b0);
		wr(A_CLR, 32'h0000_0002);
		rchk(A_STAT, 32'h0000_0000, 1'b0);
		rchk(A_CLR, 32'h0000_0000, 1'b0);
		chk(irq, 1'b0);
		$display("test irq done");
	endtask
	task automatic t_link();
		wr(A_EN, 32'h0000_0001);
		wr(A_LDT, 32'h0000_0000);
		far_u.talk(0);
		repeat (10) @(posedge clk);
		chk(det[0], 1'b1);
		repeat (15) @(posedge clk);
		chk(det[0], 1'b0);
		chk(irq, 1'b1);
		rchk(A_STAT, 32'h0000_0001, 1'b0);
		wr(A_CLR, 32'h0000_0001);
		wr(A_LDT, 32'h0000_00FC);
		rchk(A_LDT, 32'h0000_0004, 1'b0);
		// a write without the low byte strobe must leave the select alone
		pstrb <= 4'hE;
		wr(A_LDT, 32'h0000_0001);
		pstrb <= 4'hF;
		rchk(A_LDT, 32'h0000_0004, 1'b0);
		far_u.talk(1);
		repeat (400) @(posedge clk);
		chk(det[1], 1'b1);
		repeat (20) @(posedge clk);
		chk(det[1], 1'b0);
		far_u.lock(2'b00);
		far_u.talk(0);
		repeat (2) @(posedge clk);
		chk(det, 2'h0);
		$display("test link done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_autoload();
		t_modes();
		t_freeze();
		t_port();
		t_irq();
		t_link();
		stop_test();
	end
	// the run needs about 640 cycles
	initial
	begin
		repeat (8000) @(posedge clk);
		err_total++;
		stop_test();
	end
endmodule
